// ---- bmvs_analog_model.sv ----
// Purpose: comparators and soft-start ramp beside bmvs_ctrl
// Assumes: vPct is output in percent of target, compMv in mV
// Notes:   ramp length shortened for simulation
`timescale 1ns/1ns
module bmvs_analog_model #(
    parameter RAMP = 40
) (
    // Clock and reset
    input  wire       core_clk,
    input  wire       sys_rst,
    // Analog levels
    input  wire [7:0] vPct,
    input  wire [9:0] compMv,
    // Flags
    output wire       ssRampDone,
    output wire       voutAbove103,
    output wire       voutBelow97,
    output wire       overVoltage,
    output wire       compBelow0p50,
    output wire       compAbove0p55
);
    reg [7:0] ramp_q;
    always @(posedge core_clk) begin
        ramp_q <= sys_rst ? 8'h00 : ramp_q + {7'h00, ramp_q != RAMP};
    end
    assign ssRampDone    = (ramp_q == RAMP);
    assign voutAbove103  = (vPct >= 8'h67);
    assign voutBelow97   = (vPct < 8'h61);
    assign overVoltage   = (vPct >= 8'h6B);
    assign compBelow0p50 = (compMv < 10'h1F4);
    assign compAbove0p55 = (compMv > 10'h226);
endmodule

// ---- bmvs_ctrl.v ----
// Purpose: output-select strap latch and light-load mode control
// Assumes: reset is power-up or re-enable; inputs synchronous
// Notes:   analog loop, ramp and oscillator live outside
`timescale 1ns/1ns
`include "bmvs_defines.vh"
// How it works
// - Straps decode: 00=3.3V, 01=5.0V, 10=5.35V, 11=12.0V.
// - Straps sampled once after power-up; later changes ignored.
// - Select pin low lets the block enter low-power mode.
// - Select pin high keeps forced regulation mode always.
// - Enter low-power after three cycles of all entry conditions.
// - Leave low-power on overvoltage or error high for 200 ns.
// - Below 97% in low-power, switch with 600 mA peak limit.
// - At 103% stop switching until below 97% again.
// - Soft-start tied high is 0.7 ms; capacitor lengthens it.
// - Frequency by internal, resistor 400k-2.4M, or external clock.
// - During soft-start ignore select pin, stay in regulation.
module bmvs_ctrl #(
    parameter [19:0] SS_CYCLES = `BMVS_SS_INT_CYCLES
) (
    // Clock and reset
    input  wire       core_clk,
    input  wire       sys_rst,
    // Straps and pins
    input  wire       vout_strap_a,
    input  wire       vout_strap_b,
    input  wire       light_load_select_pin,
    input  wire       ssTiedHigh,
    input  wire       fsetTiedHigh,
    input  wire       syncClkPresent,
    // Analog comparator flags
    input  wire       ssRampDone,
    input  wire       voutAbove103,
    input  wire       voutBelow97,
    input  wire       overVoltage,
    input  wire       compBelow0p50,
    input  wire       compAbove0p55,
    // Outputs
    output reg  [1:0] voutSel_q,
    output reg        voutSelValid_q,
    output reg        low_power_state_q,
    output reg        lpSwitchEn_q,
    output reg        peakLimit600mA_q,
    output reg        softStartDone_q,
    output reg  [1:0] freqSrc_q
);
    wire [5:0] flagSync;
    wire       ssDone;
    reg  [1:0] state_q;
    reg  [1:0] state_d;
    reg  [1:0] entryCnt_q;
    reg  [1:0] entryCnt_d;
    reg  [7:0] compHiCnt_q;
    reg  [7:0] compHiCnt_d;
    wire       sAbove103;
    wire       sBelow97;
    wire       sOv;
    wire       sCompLo;
    wire       sCompHi;
    wire       lpAllowed;
    wire       entryOk;
    wire       exitLp;

    bmvs_sync2 #(
        .W(6)
    ) uSync (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .flagIn   ({ssRampDone, voutAbove103, voutBelow97,
                    overVoltage, compBelow0p50, compAbove0p55}),
        .flagOut  (flagSync)
    );

    bmvs_softstart #(
        .SS_CYCLES(SS_CYCLES)
    ) uSoft (
        .core_clk   (core_clk),
        .sys_rst    (sys_rst),
        .ssTiedHigh (ssTiedHigh),
        .ssDoneExt  (flagSync[5]),
        .ssDone_q   (ssDone)
    );

    assign sAbove103 = flagSync[4];
    assign sBelow97  = flagSync[3];
    assign sOv       = flagSync[2];
    assign sCompLo   = flagSync[1];
    assign sCompHi   = flagSync[0];

    always @(posedge core_clk) begin
        if (sys_rst) begin
            voutSel_q      <= `BMVS_VSEL_3V3;
            voutSelValid_q <= 1'b0;
        end else if (!voutSelValid_q) begin
            voutSelValid_q <= 1'b1;
            case ({vout_strap_a, vout_strap_b})
                2'h0:    voutSel_q <= `BMVS_VSEL_3V3;
                2'h1:    voutSel_q <= `BMVS_VSEL_5V0;
                2'h2:    voutSel_q <= `BMVS_VSEL_5V35;
                default: voutSel_q <= `BMVS_VSEL_12V0;
            endcase
        end
    end

    assign lpAllowed = ssDone && !light_load_select_pin;

    // Window between +3% and overvoltage, error low
    assign entryOk = lpAllowed && sAbove103 && !sOv && sCompLo;

    assign exitLp = sOv ||
        (sCompHi && compHiCnt_q >= `BMVS_COMP_HI_CYCLES - 1);

    always @* begin
        state_d     = state_q;
        entryCnt_d  = 2'h0;
        compHiCnt_d = 8'h00;
        case (state_q)
            `BMVS_ST_PWM: begin
                if (entryOk) begin
                    entryCnt_d = entryCnt_q + 2'h1;
                    if (entryCnt_q == `BMVS_ENTRY_CYCLES - 2'h1)
                        state_d = sBelow97 ? `BMVS_ST_LP_SW
                                           : `BMVS_ST_LP_IDLE;
                end
            end
            `BMVS_ST_LP_SW, `BMVS_ST_LP_IDLE: begin
                if (sCompHi && compHiCnt_q != 8'hFF)
                    compHiCnt_d = compHiCnt_q + 8'h01;
                if (exitLp || !lpAllowed) begin
                    state_d = `BMVS_ST_PWM;
                end else if (state_q == `BMVS_ST_LP_SW) begin
                    if (sAbove103)
                        state_d = `BMVS_ST_LP_IDLE;
                end else if (sBelow97) begin
                    state_d = `BMVS_ST_LP_SW;
                end
            end
            default: state_d = `BMVS_ST_PWM;
        endcase
    end

    always @(posedge core_clk) begin
        if (sys_rst) begin
            state_q           <= `BMVS_ST_PWM;
            entryCnt_q        <= 2'h0;
            compHiCnt_q       <= 8'h00;
            low_power_state_q <= 1'b0;
            lpSwitchEn_q      <= 1'b0;
            peakLimit600mA_q  <= 1'b0;
            softStartDone_q   <= 1'b0;
            freqSrc_q         <= `BMVS_FSEL_INT;
        end else begin
            state_q           <= state_d;
            entryCnt_q        <= entryCnt_d;
            compHiCnt_q       <= compHiCnt_d;
            low_power_state_q <= state_d != `BMVS_ST_PWM;
            lpSwitchEn_q      <= state_d == `BMVS_ST_LP_SW;
            peakLimit600mA_q  <= state_d == `BMVS_ST_LP_SW;
            softStartDone_q   <= ssDone;
            if (syncClkPresent)
                freqSrc_q <= `BMVS_FSEL_EXT;
            else if (fsetTiedHigh)
                freqSrc_q <= `BMVS_FSEL_INT;
            else
                freqSrc_q <= `BMVS_FSEL_RES;
        end
    end
endmodule

// ---- bmvs_ctrl_props.sv ----
// Purpose: port checker for bmvs_ctrl
// Assumes: raw flags reach the state machine through a two-flop sync
// Notes:   windows leave room for sync and output register latency
`timescale 1ns/1ns
module bmvs_ctrl_props (
    // Clock and reset
    input wire       core_clk,
    input wire       sys_rst,
    // Pins and flags
    input wire       light_load_select_pin,
    input wire       voutAbove103,
    input wire       voutBelow97,
    input wire       overVoltage,
    input wire       compBelow0p50,
    input wire       compAbove0p55,
    // Outputs
    input wire [1:0] voutSel_q,
    input wire       voutSelValid_q,
    input wire       low_power_state_q,
    input wire       lpSwitchEn_q,
    input wire       peakLimit600mA_q,
    input wire       softStartDone_q
);
    reg  [7:0] okHist_q;
    reg  [5:0] compRun_q;
    // Soft-start left out here: the port lags the internal flag one cycle
    wire       entryOk = voutAbove103 && !overVoltage &&
                         compBelow0p50 && !light_load_select_pin;
    wire       triple = |(okHist_q & (okHist_q >> 1) & (okHist_q >> 2));
    always @(posedge core_clk) begin
        okHist_q  <= sys_rst ? 8'h00 : {okHist_q[6:0], entryOk};
        compRun_q <= (sys_rst || !compAbove0p55) ? 6'h00 :
                     compRun_q + {5'h00, compRun_q != 6'h3F};
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    a_entry_run: assert property ($rose(low_power_state_q)
        |-> triple && $past(softStartDone_q, 2))
        else $error("low power entry without three good cycles");
    a_pin_forces: assert property (light_load_select_pin[*6]
        |-> !low_power_state_q) else $error("low power with select high");
    a_ss_first: assert property (!softStartDone_q |-> !low_power_state_q)
        else $error("low power during soft-start");
    a_ov_exit: assert property (low_power_state_q && overVoltage
        |-> ##[1:5] !low_power_state_q) else $error("no exit on overvoltage");
    a_comp_exit: assert property (compRun_q >= 6'h1A
        |-> !low_power_state_q) else $error("no exit on high error voltage");
    a_below_switch: assert property ((low_power_state_q && voutBelow97 &&
        !voutAbove103)[*5] |-> lpSwitchEn_q) else $error("no switching below");
    a_above_idle: assert property ((low_power_state_q && voutAbove103 &&
        !voutBelow97)[*5] |-> !lpSwitchEn_q) else $error("switching above");
    a_peak_match: assert property (peakLimit600mA_q == lpSwitchEn_q &&
        (!lpSwitchEn_q || low_power_state_q)) else $error("peak limit wrong");
    a_strap_kept: assert property (voutSelValid_q && $past(voutSelValid_q)
        |-> $stable(voutSel_q)) else $error("output select changed");
    cover property ($rose(low_power_state_q));
    cover property ($rose(lpSwitchEn_q));
    cover property ($fell(low_power_state_q));
endmodule
bind bmvs_ctrl bmvs_ctrl_props bmvs_ctrl_props_i (.*);

// ---- bmvs_ctrl_tb_top.sv ----
// Purpose: directed bench for bmvs_ctrl
// Assumes: soft-start shortened to 20 cycles, ramp to 40
// Notes:   flags come from the comparator model
`timescale 1ns/1ns
module bmvs_ctrl_tb_top;
    reg        core_clk = 1'b0;
    reg        sys_rst = 1'b1;
    reg        vout_strap_a = 1'b0;
    reg        vout_strap_b = 1'b0;
    reg        light_load_select_pin = 1'b0;
    reg        ssTiedHigh = 1'b1;
    reg        fsetTiedHigh = 1'b1;
    reg        syncClkPresent = 1'b0;
    reg  [7:0] vPct = 8'h64;
    reg  [9:0] compMv = 10'h190;
    wire       ssRampDone, voutAbove103, voutBelow97, overVoltage;
    wire       compBelow0p50, compAbove0p55, voutSelValid_q, softStartDone_q;
    wire       low_power_state_q, lpSwitchEn_q, peakLimit600mA_q;
    wire [1:0] voutSel_q, freqSrc_q;
    integer    fails, n_tests, i;
    bmvs_ctrl #(.SS_CYCLES(20'h00014)) bmvs_ctrl_i (.*);
    bmvs_analog_model #(.RAMP(40)) bmvs_analog_model_i (.*);
    always #5 core_clk = ~core_clk;
    task tick(input integer n);
        begin
            repeat (n) @(posedge core_clk);
            #1;
        end
    endtask
    task chk(input [95:0] what, input [1:0] e, input [1:0] g);
        begin
            n_tests = n_tests + 1;
            if (g !== e) begin
                fails = fails + 1;
                $display("mismatch %0s exp %h got %h", what, e, g);
            end
        end
    endtask
    task setIn(input [7:0] v, input [9:0] c, input p);
        begin
            @(posedge core_clk);
            vPct <= v;
            compMv <= c;
            light_load_select_pin <= p;
        end
    endtask
    task doReset;
        begin
            @(posedge core_clk);
            sys_rst <= 1'b1;
            tick(2);
            @(posedge core_clk);
            sys_rst <= 1'b0;
        end
    endtask
    function [1:0] pick(input integer s);
        pick = {1'b0, s == 0 ? low_power_state_q :
                      s == 1 ? lpSwitchEn_q : softStartDone_q};
    endfunction
    task waitFor(input integer s, input [1:0] e);
        integer k;
        begin
            k = 0;
            while (pick(s) !== e && k < 200) begin
                tick(1);
                k = k + 1;
            end
            if (k == 200) begin
                fails = fails + 1;
                tally_and_finish;
            end else begin
                chk("wait", e, pick(s));
            end
        end
    endtask
    task tally_and_finish;
        begin
            $display("comparisons %0d mismatches %0d", n_tests, fails);
            if (fails == 0 && n_tests > 0) $display("== PASSED ==");
            else $display("== FAILED ==");
            $finish;
        end
    endtask
    initial begin
        fails = 0;
        n_tests = 0;
        for (i = 0; i < 4; i = i + 1) begin
            @(posedge core_clk);
            {vout_strap_a, vout_strap_b} <= i[1:0];
            fsetTiedHigh <= (i == 0);
            syncClkPresent <= (i == 2);
            doReset;
            tick(3);
            chk("vsel", i[1:0], voutSel_q);
            chk("valid", 2'h1, {1'b0, voutSelValid_q});
            chk("freq", (i == 3) ? 2'h1 : i[1:0], freqSrc_q);
            @(posedge core_clk);
            {vout_strap_a, vout_strap_b} <= ~i[1:0];
            tick(3);
            chk("vhold", i[1:0], voutSel_q);
        end
        setIn(8'h68, 10'h190, 1'b0);
        doReset;
        tick(10);
        chk("ssLp", 2'h0, pick(0));
        chk("ssEarly", 2'h0, pick(2));
        waitFor(2, 2'h1);
        waitFor(0, 2'h1);
        chk("idle", 2'h0, pick(1));
        setIn(8'h60, 10'h190, 1'b0);
        waitFor(1, 2'h1);
        chk("peak", 2'h1, {1'b0, peakLimit600mA_q});
        setIn(8'h67, 10'h190, 1'b0);
        waitFor(1, 2'h0);
        setIn(8'h67, 10'h258, 1'b0);
        tick(17);
        setIn(8'h67, 10'h190, 1'b0);
        tick(6);
        chk("shortHi", 2'h1, pick(0));
        setIn(8'h67, 10'h258, 1'b0);
        tick(19);
        chk("midHi", 2'h1, pick(0));
        waitFor(0, 2'h0);
        setIn(8'h68, 10'h190, 1'b0);
        tick(1);
        setIn(8'h64, 10'h190, 1'b0);
        tick(10);
        chk("twoRun", 2'h0, pick(0));
        setIn(8'h68, 10'h190, 1'b0);
        waitFor(0, 2'h1);
        setIn(8'h6C, 10'h190, 1'b0);
        tick(5);
        chk("ovExit", 2'h0, pick(0));
        setIn(8'h68, 10'h190, 1'b1);
        tick(30);
        chk("pinHigh", 2'h0, pick(0));
        @(posedge core_clk);
        ssTiedHigh <= 1'b0;
        doReset;
        tick(25);
        chk("capEarly", 2'h0, pick(2));
        waitFor(2, 2'h1);
        tally_and_finish;
    end
endmodule

// ---- bmvs_defines.vh ----
// Purpose: constants for the buck mode and output-select control
// Assumes: core_clk at 100 MHz
// Notes:   codes for output target and mode states
`ifndef BMVS_DEFINES_VH
`define BMVS_DEFINES_VH
`define BMVS_CLK_PERIOD_NS   10
`define BMVS_VSEL_3V3        2'h0
`define BMVS_VSEL_5V0        2'h1
`define BMVS_VSEL_5V35       2'h2
`define BMVS_VSEL_12V0       2'h3
`define BMVS_ENTRY_CYCLES    2'h3
`define BMVS_COMP_HI_NS      200
`define BMVS_COMP_HI_CYCLES  ((`BMVS_COMP_HI_NS + `BMVS_CLK_PERIOD_NS - 1) / `BMVS_CLK_PERIOD_NS)
`define BMVS_SS_INT_MS       7
`define BMVS_SS_INT_DIV      10
`define BMVS_SS_INT_CYCLES   ((`BMVS_SS_INT_MS * 1000000 / `BMVS_SS_INT_DIV) / `BMVS_CLK_PERIOD_NS)
`define BMVS_ST_PWM          2'h0
`define BMVS_ST_LP_SW        2'h1
`define BMVS_ST_LP_IDLE      2'h2
`define BMVS_FSEL_INT        2'h0
`define BMVS_FSEL_RES        2'h1
`define BMVS_FSEL_EXT        2'h2
`endif

// ---- bmvs_softstart.v ----
// Purpose: soft-start timer, internal fixed or external capacitor
// Assumes: ssDoneExt is a synchronised comparator flag
// Notes:   long count is a parameter so simulation can shorten it
`timescale 1ns/1ns
`include "bmvs_defines.vh"
module bmvs_softstart #(
    parameter [19:0] SS_CYCLES = `BMVS_SS_INT_CYCLES
) (
    // Clock and reset
    input  wire core_clk,
    input  wire sys_rst,
    // Control
    input  wire ssTiedHigh,
    input  wire ssDoneExt,
    output reg  ssDone_q
);
    reg [19:0] count_q;
    always @(posedge core_clk) begin
        if (sys_rst) begin
            count_q  <= 20'h00000;
            ssDone_q <= 1'b0;
        end else if (!ssDone_q) begin
            if (ssTiedHigh) begin
                if (count_q >= SS_CYCLES - 20'h00001)
                    ssDone_q <= 1'b1;
                count_q <= count_q + 20'h00001;
            end else if (ssDoneExt) begin
                ssDone_q <= 1'b1;
            end
        end
    end
endmodule

// ---- bmvs_sync2.v ----
// Purpose: two-flop synchroniser, one per comparator flag
// Assumes: flags are slow analog levels
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ns
module bmvs_sync2 #(
    parameter W = 8
) (
    // Clock and reset
    input  wire         core_clk,
    input  wire         sys_rst,
    // Flags
    input  wire [W-1:0] flagIn,
    output wire [W-1:0] flagOut
);
    reg [W-1:0] stage1_q;
    reg [W-1:0] stage2_q;
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : gBit
            always @(posedge core_clk) begin
                if (sys_rst) begin
                    stage1_q[i] <= 1'b0;
                    stage2_q[i] <= 1'b0;
                end else begin
                    stage1_q[i] <= flagIn[i];
                    stage2_q[i] <= stage1_q[i];
                end
            end
        end
    endgenerate
    assign flagOut = stage2_q;
endmodule
